// >>> rtl/hdcp_top.sv
// Haptic drive config and protection register bank
//
// Contract
// - Real-time mode drives magnitude in 0.78% steps
// - Amplitude top bit selects drive polarity
// - Playback starts at stored pattern start address
// - Disabled outputs: low-side clamp or 15k pull-down
// - Overtemperature locks driver, interrupts, sets flag
// - Switch overcurrent locks driver, interrupts, sets flag
// - Flag and lock stay until release written
// - Release bit returns to zero by itself
// - Brake measure uses four or two samples
// - Saturation-exit bit ends braking on counter saturation
// - Brake-disable bit skips automatic braking
// - Resonance detection runs only when enabled
// - Actuator-type bit selects rotating-mass or linear
// - Level compensation only while its enable set
// - Hysteresis bit adds about 6mV comparator hysteresis
`timescale 1ns/1ps
`include "hdcp_map.svh"
`default_nettype none
module hdcp_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// Drive mode control from the device register file
	input wire logic [4:0] drive_mode_field_i,
	input wire logic driver_clock_enable_i,
	// Fault pins from the output stage
	input wire logic overtemp_i,
	input wire logic [3:0] overcurrent_i,
	// Braking engine status
	input wire logic brake_active_i,
	input wire logic zc_counter_sat_i,
	// Drive outputs
	output logic drive_enable_o,
	output logic [6:0] amp_code_o,
	output logic drive_polarity_o,
	output logic [7:0] pattern_start_addr_o,
	output logic pattern_load_o,
	output logic low_side_clamp_o,
	output logic pulldown_15k_o,
	// Protection status
	output logic driver_locked_o,
	output logic driver_fault_flag_o,
	output logic overtemp_irq_o,
	output logic pos_low_switch_overcurrent_irq_o,
	output logic neg_low_switch_overcurrent_irq_o,
	output logic pos_high_switch_overcurrent_irq_o,
	output logic neg_high_switch_overcurrent_irq_o,
	// Braking and resonance configuration
	output logic brake_two_point_o,
	output logic auto_brake_enable_o,
	output logic brake_saturation_stop_o,
	output logic resonance_detect_run_o,
	output logic actuator_lra_o,
	output logic level_comp_run_o,
	output logic zero_cross_hysteresis_o
);
	// ----------------------------------------------------------------
	// Reset release synchroniser
	// ----------------------------------------------------------------
	logic rst_meta_q;
	logic rst_n;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// Fault pin synchronisers
	// ----------------------------------------------------------------
	logic [4:0] pin_meta_q;
	logic [4:0] pin_sync_q;
	logic [4:0] pin_raw;

	assign pin_raw = {overtemp_i, overcurrent_i};

	// Two flops per pin; only the second stage is read by logic
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_sync
			always_ff @(posedge clk_i or negedge rst_n) begin
				if (!rst_n) begin
					pin_meta_q[gi] <= 1'b0;
					pin_sync_q[gi] <= 1'b0;
				end else begin
					pin_meta_q[gi] <= pin_raw[gi];
					pin_sync_q[gi] <= pin_meta_q[gi];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [7:0] rt_amp_q;
	logic [7:0] pat_addr_q;
	logic [7:0] prot_q;
	logic [7:0] cfg_q;
	hdcp_pkg::hdcp_release_t rel_q;
	logic wr_rel_one;

	assign wr_rel_one = reg_wr_i && (reg_addr_i == `HDCP_OFF_RELEASE)
		&& reg_wdata_i[`HDCP_RELEASE_BIT];

	// Plain read/write registers; unused bits are masked so they read zero
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rt_amp_q <= `HDCP_RST_RT_AMP;
			pat_addr_q <= `HDCP_RST_PAT_ADDR;
			prot_q <= `HDCP_RST_PROT;
			cfg_q <= `HDCP_RST_BRAKE_CFG;
		end else if (reg_wr_i) begin
			unique case (reg_addr_i)
				`HDCP_OFF_RT_AMP: begin
					rt_amp_q <= reg_wdata_i;
				end
				`HDCP_OFF_PAT_ADDR: begin
					pat_addr_q <= reg_wdata_i;
				end
				`HDCP_OFF_PROT: begin
					prot_q <= reg_wdata_i & `HDCP_PROT_MASK;
				end
				`HDCP_OFF_BRAKE_CFG: begin
					cfg_q <= reg_wdata_i & `HDCP_CFG_MASK;
				end
				default: begin
				end
			endcase
		end
	end

	// Release request lives one cycle, then the bit falls back to zero
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rel_q <= hdcp_pkg::HDCP_REL_IDLE;
		end else begin
			unique case (rel_q)
				hdcp_pkg::HDCP_REL_IDLE: begin
					if (wr_rel_one) begin
						rel_q <= hdcp_pkg::HDCP_REL_PEND;
					end
				end
				hdcp_pkg::HDCP_REL_PEND: begin
					if (!wr_rel_one) begin
						rel_q <= hdcp_pkg::HDCP_REL_IDLE;
					end
				end
			endcase
		end
	end

	// Read data is registered; unmapped offsets answer zero
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				`HDCP_OFF_RT_AMP: reg_rdata_o <= rt_amp_q;
				`HDCP_OFF_PAT_ADDR: reg_rdata_o <= pat_addr_q;
				`HDCP_OFF_PROT: reg_rdata_o <= prot_q;
				`HDCP_OFF_RELEASE: reg_rdata_o <= {7'h00, rel_q == hdcp_pkg::HDCP_REL_PEND};
				`HDCP_OFF_BRAKE_CFG: reg_rdata_o <= cfg_q;
				default: reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Fault lock unit
	// ----------------------------------------------------------------
	hdcp_fault_if fault_bus ();

	// Disable bits gate the synchronised fault pins before they can lock
	assign fault_bus.thm_evt = pin_sync_q[4] & ~prot_q[`HDCP_PROT_THM_DIS_BIT];
	assign fault_bus.oc_evt = pin_sync_q[3:0]
		& {4{~prot_q[`HDCP_PROT_OC_DIS_BIT]}};
	assign fault_bus.release_req = (rel_q == hdcp_pkg::HDCP_REL_PEND);

	hdcp_fault_lock u_fault (
		.clk_i(clk_i),
		.rst_ni(rst_n),
		.f(fault_bus.unit)
	);

	// ----------------------------------------------------------------
	// Drive path
	// ----------------------------------------------------------------
	logic active;
	logic rt_mode;
	logic pb_mode;
	logic pb_run_q;

	// Host keeps the clock enable up for the whole vibration
	assign active = driver_clock_enable_i && (drive_mode_field_i != `HDCP_MODE_OFF)
		&& !fault_bus.locked;
	assign rt_mode = (drive_mode_field_i == `HDCP_MODE_RT);
	assign pb_mode = (drive_mode_field_i >= `HDCP_MODE_PB_FIRST)
		&& (drive_mode_field_i <= `HDCP_MODE_PB_LAST);

	// Magnitude is a 0.78% step code; host opens with positive sign
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			drive_enable_o <= 1'b0;
			amp_code_o <= 7'h00;
			drive_polarity_o <= 1'b0;
		end else begin
			drive_enable_o <= active;
			amp_code_o <= (active && rt_mode) ? rt_amp_q[6:0] : 7'h00;
			drive_polarity_o <= active && rt_mode
				&& rt_amp_q[`HDCP_AMP_SIGN_BIT];
		end
	end

	// Load pulse fires once as playback begins; start address is copied every cycle
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pb_run_q <= 1'b0;
			pattern_load_o <= 1'b0;
			pattern_start_addr_o <= 8'h00;
		end else begin
			pb_run_q <= active && pb_mode;
			pattern_load_o <= active && pb_mode && !pb_run_q;
			pattern_start_addr_o <= pat_addr_q;
		end
	end

	// Off-state termination whenever the driver is not running
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			low_side_clamp_o <= 1'b1;
			pulldown_15k_o <= 1'b0;
		end else begin
			low_side_clamp_o <= !active && !prot_q[`HDCP_PROT_OFF_IMP_BIT];
			pulldown_15k_o <= !active && prot_q[`HDCP_PROT_OFF_IMP_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Protection status outputs
	// ----------------------------------------------------------------
	assign driver_locked_o = fault_bus.locked;
	assign driver_fault_flag_o = fault_bus.fault_flag;
	assign overtemp_irq_o = fault_bus.thm_irq;
	assign pos_low_switch_overcurrent_irq_o = fault_bus.oc_irq[`HDCP_OC_POS_LOW];
	assign neg_low_switch_overcurrent_irq_o = fault_bus.oc_irq[`HDCP_OC_NEG_LOW];
	assign pos_high_switch_overcurrent_irq_o = fault_bus.oc_irq[`HDCP_OC_POS_HIGH];
	assign neg_high_switch_overcurrent_irq_o = fault_bus.oc_irq[`HDCP_OC_NEG_HIGH];

	// ----------------------------------------------------------------
	// Braking and resonance controls
	// ----------------------------------------------------------------
	// Run-type controls are gated by an active driver so they never act while locked
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			brake_two_point_o <= 1'b0;
			auto_brake_enable_o <= 1'b0;
			brake_saturation_stop_o <= 1'b0;
			resonance_detect_run_o <= 1'b0;
			actuator_lra_o <= 1'b0;
			level_comp_run_o <= 1'b0;
			zero_cross_hysteresis_o <= 1'b0;
		end else begin
			brake_two_point_o <= cfg_q[`HDCP_CFG_SAMPLE_SEL_BIT];
			auto_brake_enable_o <= !cfg_q[`HDCP_CFG_BRAKE_DIS_BIT];
			brake_saturation_stop_o <= cfg_q[`HDCP_CFG_SAT_EXIT_BIT]
				&& brake_active_i && zc_counter_sat_i;
			resonance_detect_run_o <= active && cfg_q[`HDCP_CFG_RES_EN_BIT];
			actuator_lra_o <= cfg_q[`HDCP_CFG_ACT_TYPE_BIT];
			level_comp_run_o <= active && cfg_q[`HDCP_CFG_ALC_EN_BIT];
			zero_cross_hysteresis_o <= cfg_q[`HDCP_CFG_ZC_HYS_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_rt_amp_code: assert property (@(posedge clk_i) disable iff (!rst_n)
		(active && rt_mode) |=> (amp_code_o == $past(rt_amp_q[6:0])))
		else $error("real-time amplitude code mismatch");
	chk_polarity_sign: assert property (@(posedge clk_i) disable iff (!rst_n)
		(active && rt_mode) |=> (drive_polarity_o == $past(rt_amp_q[7])))
		else $error("polarity does not follow sign bit");
	chk_pattern_load: assert property (@(posedge clk_i) disable iff (!rst_n)
		pattern_load_o |-> (pattern_start_addr_o == $past(pat_addr_q)))
		else $error("playback loaded wrong start address");
	chk_off_termination: assert property (@(posedge clk_i) disable iff (!rst_n)
		!active |=> (low_side_clamp_o != pulldown_15k_o) && !drive_enable_o)
		else $error("off-state termination wrong");
	chk_release_clears: assert property (@(posedge clk_i) disable iff (!rst_n)
		(fault_bus.release_req && !wr_rel_one)
		|=> (rel_q == hdcp_pkg::HDCP_REL_IDLE))
		else $error("release bit did not self-clear");
	chk_zero_no_release: assert property (@(posedge clk_i) disable iff (!rst_n)
		(rel_q == hdcp_pkg::HDCP_REL_IDLE && !wr_rel_one) |=> !fault_bus.release_req)
		else $error("release without a one written");
	chk_thm_disabled: assert property (@(posedge clk_i) disable iff (!rst_n)
		(prot_q[1] && !driver_fault_flag_o && pin_sync_q[3:0] == 4'h0) |=> !overtemp_irq_o)
		else $error("thermal interrupt while protection disabled");
	chk_locked_idle: assert property (@(posedge clk_i) disable iff (!rst_n)
		driver_locked_o |=> !drive_enable_o)
		else $error("driver enabled while locked");
	chk_brake_exit: assert property (@(posedge clk_i) disable iff (!rst_n)
		!cfg_q[5] |=> !brake_saturation_stop_o)
		else $error("brake exit while saturation exit off");
	cov_rt_negative: cover property (@(posedge clk_i) disable iff (!rst_n)
		drive_enable_o && !drive_polarity_o ##[1:20] drive_polarity_o);
	cov_playback: cover property (@(posedge clk_i) disable iff (!rst_n) pattern_load_o);
	cov_oc_lock: cover property (@(posedge clk_i) disable iff (!rst_n)
		pos_high_switch_overcurrent_irq_o ##1 driver_locked_o);
endmodule
`default_nettype wire

// >>> rtl/hdcp_map.svh
// Register offsets, field positions, reset values and mode codes of the haptic config block
`ifndef HDCP_MAP_SVH
`define HDCP_MAP_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define HDCP_OFF_RT_AMP 8'h0a
`define HDCP_OFF_PAT_ADDR 8'h0b
`define HDCP_OFF_PROT 8'h0c
`define HDCP_OFF_RELEASE 8'h0d
`define HDCP_OFF_BRAKE_CFG 8'h11
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define HDCP_AMP_SIGN_BIT 7
`define HDCP_PROT_OFF_IMP_BIT 2
`define HDCP_PROT_THM_DIS_BIT 1
`define HDCP_PROT_OC_DIS_BIT 0
`define HDCP_RELEASE_BIT 0
`define HDCP_CFG_SAMPLE_SEL_BIT 6
`define HDCP_CFG_SAT_EXIT_BIT 5
`define HDCP_CFG_BRAKE_DIS_BIT 4
`define HDCP_CFG_RES_EN_BIT 3
`define HDCP_CFG_ACT_TYPE_BIT 2
`define HDCP_CFG_ALC_EN_BIT 1
`define HDCP_CFG_ZC_HYS_BIT 0
// Writable bits of the narrow registers; the rest read as zero
`define HDCP_PROT_MASK 8'h07
`define HDCP_CFG_MASK 8'h7f
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define HDCP_RST_RT_AMP 8'h00
`define HDCP_RST_PAT_ADDR 8'h00
`define HDCP_RST_PROT 8'h00
`define HDCP_RST_BRAKE_CFG 8'h00
// ----------------------------------------------------------------
// Drive mode codes
// ----------------------------------------------------------------
`define HDCP_MODE_OFF 5'h00
`define HDCP_MODE_RT 5'h06
`define HDCP_MODE_PB_FIRST 5'h0d
`define HDCP_MODE_PB_LAST 5'h12
// Overcurrent input lane order
`define HDCP_OC_POS_LOW 0
`define HDCP_OC_NEG_LOW 1
`define HDCP_OC_POS_HIGH 2
`define HDCP_OC_NEG_HIGH 3
`define HDCP_OC_LANES 4
`endif

// >>> rtl/hdcp_pkg.sv
// Types shared by the haptic config block
package hdcp_pkg;
	// State of the self-clearing fault release request
	typedef enum logic [0:0] {
		HDCP_REL_IDLE = 1'b0,
		HDCP_REL_PEND = 1'b1
	} hdcp_release_t;
endpackage

// >>> rtl/hdcp_fault_if.sv
// Signals between the register bank and the fault lock unit
`timescale 1ns/1ps
`default_nettype none
interface hdcp_fault_if;
	logic thm_evt;
	logic [3:0] oc_evt;
	logic release_req;
	logic locked;
	logic fault_flag;
	logic thm_irq;
	logic [3:0] oc_irq;
	modport ctrl (output thm_evt, output oc_evt, output release_req,
		input locked, input fault_flag, input thm_irq, input oc_irq);
	modport unit (input thm_evt, input oc_evt, input release_req,
		output locked, output fault_flag, output thm_irq, output oc_irq);
endinterface
`default_nettype wire

// >>> rtl/hdcp_fault_lock.sv
// Fault lock unit: sticky fault flag, driver lock and event pulses
`timescale 1ns/1ps
`default_nettype none
module hdcp_fault_lock (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_ni,
	// Link to the register bank
	hdcp_fault_if.unit f
);
	logic flag_q;
	logic thm_prev_q;
	logic [3:0] oc_prev_q;
	logic thm_irq_q;
	logic [3:0] oc_irq_q;
	logic any_evt;

	assign any_evt = f.thm_evt | (|f.oc_evt);

	// ----------------------------------------------------------------
	// Sticky flag: a new fault in the release cycle keeps it set
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_ni) begin
		if (!rst_ni) begin
			flag_q <= 1'b0;
		end else if (any_evt) begin
			flag_q <= 1'b1;
		end else if (f.release_req) begin
			flag_q <= 1'b0;
		end
	end

	// Event pulses on the rising edge of each qualified fault
	always_ff @(posedge clk_i or negedge rst_ni) begin
		if (!rst_ni) begin
			thm_prev_q <= 1'b0;
			oc_prev_q <= 4'h0;
			thm_irq_q <= 1'b0;
			oc_irq_q <= 4'h0;
		end else begin
			thm_prev_q <= f.thm_evt;
			oc_prev_q <= f.oc_evt;
			thm_irq_q <= f.thm_evt & ~thm_prev_q;
			oc_irq_q <= f.oc_evt & ~oc_prev_q;
		end
	end

	// Lock follows the flag, so only a release can restart the driver
	assign f.locked = flag_q;
	assign f.fault_flag = flag_q;
	assign f.thm_irq = thm_irq_q;
	assign f.oc_irq = oc_irq_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_fault_sets_flag: assert property (@(posedge clk_i) disable iff (!rst_ni)
		any_evt |=> flag_q)
		else $error("fault event did not set the flag");
	chk_flag_holds: assert property (@(posedge clk_i) disable iff (!rst_ni)
		(flag_q && !f.release_req) |=> flag_q)
		else $error("fault flag cleared without release");
	chk_thm_pulse: assert property (@(posedge clk_i) disable iff (!rst_ni)
		$rose(f.thm_evt) |=> f.thm_irq ##1 !f.thm_irq)
		else $error("thermal event pulse wrong");
	cov_fault_release: cover property (@(posedge clk_i) disable iff (!rst_ni)
		flag_q ##1 f.release_req ##1 !flag_q);
endmodule
`default_nettype wire

// >>> test/hdcp_stage_model.sv
// Behavioural model of the output stage and braking engine beside the haptic config block
`timescale 1ns/1ps
`default_nettype none
module hdcp_stage_model (
	// Clock
	input wire logic clk_i,
	// Commands from the bench
	input wire logic [4:0] fault_cmd_i,
	input wire logic brake_cmd_i,
	input wire logic sat_cmd_i,
	// Pins toward the block
	output logic overtemp_o,
	output logic [3:0] overcurrent_o,
	output logic brake_active_o,
	output logic zc_counter_sat_o
);
	// --------------------------------------------------------
	// Fault comparators
	// --------------------------------------------------------
	// Pins move off the clock grid, so the block's synchroniser is exercised
	assign #7 overtemp_o = fault_cmd_i[4];
	assign #7 overcurrent_o = fault_cmd_i[3:0];
	// --------------------------------------------------------
	// Braking engine status
	// --------------------------------------------------------
	// The counter only runs inside a braking window, so saturation needs one
	always @(posedge clk_i) begin
		brake_active_o <= brake_cmd_i;
		zc_counter_sat_o <= brake_cmd_i & sat_cmd_i;
	end
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking testbench of the haptic config and protection block
`timescale 1ns/1ps
`include "hdcp_map.svh"
`default_nettype none
module tb_top;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic [4:0] mode = 5'h00;
	logic clk_en = 1'b0;
	logic [4:0] fault_cmd = 5'h00;
	logic brake_cmd = 1'b0;
	logic sat_cmd = 1'b0;
	wire logic overtemp, brake_active, zc_sat;
	wire logic [3:0] overcurrent;
	wire logic [7:0] reg_rdata_o;
	wire logic drive_enable_o, drive_polarity_o, pattern_load_o, low_side_clamp_o;
	wire logic pulldown_15k_o, driver_locked_o, driver_fault_flag_o;
	wire logic [6:0] amp_code_o, cfg_out;
	wire logic [7:0] pattern_start_addr_o;
	wire logic [4:0] irqs;
	int failures = 0;
	int checks_done = 0;
	int cycles = 0;
	int loads = 0;
	int irq_cnt [5];
	int base;
	// --------------------------------------------------------
	// Instances
	// --------------------------------------------------------
	hdcp_top u_hdcp_top (.clk_i(clk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .drive_mode_field_i(mode), .driver_clock_enable_i(clk_en),
		.overtemp_i(overtemp), .overcurrent_i(overcurrent), .brake_active_i(brake_active),
		.zc_counter_sat_i(zc_sat), .drive_enable_o(drive_enable_o), .amp_code_o(amp_code_o),
		.drive_polarity_o(drive_polarity_o), .pattern_start_addr_o(pattern_start_addr_o),
		.pattern_load_o(pattern_load_o), .low_side_clamp_o(low_side_clamp_o),
		.pulldown_15k_o(pulldown_15k_o), .driver_locked_o(driver_locked_o),
		.driver_fault_flag_o(driver_fault_flag_o), .overtemp_irq_o(irqs[4]),
		.pos_low_switch_overcurrent_irq_o(irqs[0]), .neg_low_switch_overcurrent_irq_o(irqs[1]),
		.pos_high_switch_overcurrent_irq_o(irqs[2]), .neg_high_switch_overcurrent_irq_o(irqs[3]),
		.brake_two_point_o(cfg_out[6]), .auto_brake_enable_o(cfg_out[4]),
		.brake_saturation_stop_o(cfg_out[5]), .resonance_detect_run_o(cfg_out[3]),
		.actuator_lra_o(cfg_out[2]), .level_comp_run_o(cfg_out[1]),
		.zero_cross_hysteresis_o(cfg_out[0]));
	hdcp_stage_model u_hdcp_stage_model (.clk_i(clk_i), .fault_cmd_i(fault_cmd),
		.brake_cmd_i(brake_cmd), .sat_cmd_i(sat_cmd), .overtemp_o(overtemp),
		.overcurrent_o(overcurrent), .brake_active_o(brake_active), .zc_counter_sat_o(zc_sat));
	// --------------------------------------------------------
	// Clock, timeout and pulse counters
	// --------------------------------------------------------
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	// Pulses last one cycle, so they are counted rather than sampled
	always @(posedge clk_i) begin
		cycles++;
		if (pattern_load_o === 1'b1) loads++;
		for (int i = 0; i < 5; i++) if (irqs[i] === 1'b1) irq_cnt[i]++;
		if (cycles == 6000) begin
			failures++;
			conclude();
		end
	end
	// --------------------------------------------------------
	// Tasks
	// --------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= addr;
		reg_wdata_i <= data;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	// Read data is registered at the taking edge and sampled just after it
	task automatic rd(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= addr;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		data = reg_rdata_o;
	endtask
	task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
		logic [7:0] v;
		rd(addr, v);
		check(v, exp);
	endtask
	task automatic set_drive(input logic [4:0] m);
		@(posedge clk_i);
		mode <= m;
		tick(4);
	endtask
	task automatic conclude();
		if (failures == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// --------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------
	initial begin
		for (int i = 0; i < 5; i++) irq_cnt[i] = 0;
		repeat (5) @(posedge clk_i);
		resetn_i <= 1'b1;
		tick(4);
		// Idle outputs after reset: clamp to ground, braking on
		check(8'(low_side_clamp_o), 8'h01);
		check(8'(cfg_out), 8'h10);
		rd_chk(`HDCP_OFF_RT_AMP, 8'h00);
		rd_chk(`HDCP_OFF_PAT_ADDR, 8'h00);
		rd_chk(`HDCP_OFF_RELEASE, 8'h00);
		rd_chk(`HDCP_OFF_PROT, 8'h00);
		rd_chk(`HDCP_OFF_BRAKE_CFG, 8'h00);
		// Narrow registers keep only their fields; unmapped place reads zero
		wr(`HDCP_OFF_PROT, 8'hf8);
		rd_chk(`HDCP_OFF_PROT, 8'h00);
		wr(8'h0e, 8'h5a);
		rd_chk(8'h0e, 8'h00);
		wr(`HDCP_OFF_BRAKE_CFG, 8'hff);
		rd_chk(`HDCP_OFF_BRAKE_CFG, 8'h7f);
		// Off impedance while the driver is idle
		wr(`HDCP_OFF_PROT, 8'h04);
		tick(3);
		check({6'h00, low_side_clamp_o, pulldown_15k_o}, 8'h01);
		wr(`HDCP_OFF_PROT, 8'h00);
		tick(3);
		check({6'h00, low_side_clamp_o, pulldown_15k_o}, 8'h02);
		// Real-time amplitude: clock enable first, positive value first
		@(posedge clk_i);
		clk_en <= 1'b1;
		wr(`HDCP_OFF_RT_AMP, 8'h35);
		set_drive(`HDCP_MODE_RT);
		check({drive_polarity_o, amp_code_o}, 8'h35);
		check({6'h00, low_side_clamp_o, pulldown_15k_o}, 8'h00);
		wr(`HDCP_OFF_RT_AMP, 8'h85);
		tick(3);
		check({drive_polarity_o, amp_code_o}, 8'h85);
		// Each config bit alone, driver active and braking window saturated
		brake_cmd <= 1'b1;
		sat_cmd <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			wr(`HDCP_OFF_BRAKE_CFG, 8'(1 << i));
			tick(3);
			check(8'(cfg_out), 8'(1 << i) ^ 8'h10);
		end
		wr(`HDCP_OFF_BRAKE_CFG, 8'h2a);
		brake_cmd <= 1'b0;
		set_drive(`HDCP_MODE_OFF);
		// Outside braking and with the driver idle the gated controls drop
		check(8'(cfg_out), 8'h10);
		check({drive_enable_o, amp_code_o}, 8'h00);
		// Playback start address and load pulse over the mode boundary codes
		wr(`HDCP_OFF_PAT_ADDR, 8'h5c);
		rd_chk(`HDCP_OFF_PAT_ADDR, 8'h5c);
		for (int m = 5'h0c; m <= 5'h13; m++) begin
			base = loads;
			set_drive(5'(m));
			check(8'(loads - base), 8'(m >= 5'h0d && m <= 5'h12));
			set_drive(`HDCP_MODE_OFF);
		end
		check(pattern_start_addr_o, 8'h5c);
		// Each fault lane locks the driver; only a release of one unlocks it
		set_drive(`HDCP_MODE_RT);
		for (int k = 0; k < 5; k++) begin
			base = irq_cnt[k];
			fault_cmd <= 5'(1 << k);
			tick(6);
			fault_cmd <= 5'h00;
			check({driver_fault_flag_o, driver_locked_o, drive_enable_o}, 8'h06);
			check(8'(irq_cnt[k] - base), 8'h01);
			tick(4);
			wr(`HDCP_OFF_RELEASE, 8'h00);
			tick(3);
			check({driver_fault_flag_o, driver_locked_o}, 8'h03);
			wr(`HDCP_OFF_RELEASE, 8'h01);
			rd_chk(`HDCP_OFF_RELEASE, 8'h00);
			tick(2);
			check({driver_fault_flag_o, driver_locked_o, drive_enable_o}, 8'h01);
		end
		// A release while the fault persists leaves the lock in place
		fault_cmd <= 5'h01;
		tick(6);
		wr(`HDCP_OFF_RELEASE, 8'h01);
		tick(3);
		check(8'(driver_fault_flag_o), 8'h01);
		fault_cmd <= 5'h00;
		tick(4);
		wr(`HDCP_OFF_RELEASE, 8'h01);
		tick(2);
		check({driver_fault_flag_o, driver_locked_o}, 8'h00);
		// Disabled protections ignore their pins
		wr(`HDCP_OFF_PROT, 8'h03);
		base = irq_cnt[4] + irq_cnt[2];
		fault_cmd <= 5'h14;
		tick(6);
		check({driver_fault_flag_o, drive_enable_o}, 8'h01);
		check(8'(irq_cnt[4] + irq_cnt[2] - base), 8'h00);
		fault_cmd <= 5'h00;
		tick(4);
		conclude();
	end
endmodule
`default_nettype wire
